/* File: lpsc_ctrl.sv */
/*
  Link power state controller of the convergence sublayer: tracks the
  full-power, low-power and idle states and sequences the downstream
  bits-per-path changes around the sync flag primitive.
  Assumes the control entity issues a command only after the matching
  handshake has completed, and that the physical media function pulses
  symbol start, sync confirm and sync indicate for one cycle each.
*/
`include "lpsc_map.svh"

module lpsc_ctrl #(
  parameter int NPATH = 4,
  parameter int LPW = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Control entity
  input wire lpsc_pkg::lpsc_cmd_s i_cmd,
  input wire logic [NPATH-1:0] i_path_used,
  input wire logic [NPATH*LPW-1:0] i_low_lp,
  input wire logic [NPATH*LPW-1:0] i_full_lp,
  output logic o_cmd_reject,
  output lpsc_pkg::lpsc_stat_s o_stat,
  // Physical media function
  input wire logic i_symbol_start,
  input wire logic i_sync_cnf,
  input wire logic i_sync_ind,
  output logic o_sync_req,
  output logic [NPATH*LPW-1:0] o_tx_lp,
  output logic [NPATH*LPW-1:0] o_rx_lp
);
  import lpsc_pkg::*;

  if (NPATH < 1 || NPATH > 256 || LPW < 11 || LPW > 16) begin : g_bad_param
    $error("lpsc_ctrl: NPATH must be within 1..256 and LPW within 11..16");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  lpsc_link_e link_q, link_d;
  lpsc_seq_e seq_q, seq_d;
  logic req_q, req_d, cnf_q, cnf_d, ind_q, ind_d;
  logic tx_done_q, tx_done_d, rx_done_q, rx_done_d, rej_q, rej_d;
  logic [NPATH-1:0] used_q, used_d;
  logic init_load, tgt_load, save, tx_load, rx_load;
  logic [NPATH*LPW-1:0] saved_lp, src_lp;

  function automatic logic lp_ok(input logic [NPATH*LPW-1:0] lp,
                                 input logic [NPATH-1:0] used);
    logic [LPW+7:0] sum;
    logic ok;
    logic [LPW-1:0] v;
    sum = '0;
    ok = 1'b1;
    for (int p = 0; p < NPATH; p++) begin
      v = lp[p*LPW +: LPW];
      if (used[p]) begin
        if (v < LPW'(`LPSC_LP_MIN) || v > LPW'(`LPSC_LP_MAX)) ok = 1'b0;
        sum = sum + (LPW+8)'(v);
      end
    end
    if (sum < (LPW+8)'(`LPSC_SUM_MIN) || sum > (LPW+8)'(`LPSC_SUM_MAX)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : lp_ok

  // ----------------------------------------------------------------------
  // Link state sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    link_d = link_q;
    seq_d = seq_q;
    req_d = req_q;
    cnf_d = cnf_q;
    ind_d = ind_q;
    tx_done_d = tx_done_q;
    rx_done_d = rx_done_q;
    used_d = used_q;
    rej_d = 1'b0;
    init_load = 1'b0;
    tgt_load = 1'b0;
    save = 1'b0;
    tx_load = 1'b0;
    rx_load = 1'b0;
    src_lp = i_full_lp;
    if (i_cmd.valid && i_cmd.code == lpsc_cmd_power_loss &&
        link_q != idle_state) begin
      // Sudden power loss drops straight to idle from either live state.
      link_d = idle_state;
      seq_d = lpsc_seq_steady;
      req_d = 1'b0;
      cnf_d = 1'b0;
      ind_d = 1'b0;
      tx_done_d = 1'b0;
      rx_done_d = 1'b0;
    end else if (seq_q == lpsc_seq_steady) begin
      if (i_cmd.valid) begin
        case (i_cmd.code)
          lpsc_cmd_enter_low: begin
            if (link_q == full_power_state &&
                lp_ok(i_low_lp, i_path_used)) begin
              src_lp = i_low_lp;
              tgt_load = 1'b1;
              save = 1'b1;
              used_d = i_path_used;
              req_d = 1'b1;
              seq_d = lpsc_seq_enter;
            end else begin
              rej_d = 1'b1;
            end
          end
          lpsc_cmd_exit_low: begin
            if (link_q == low_power_state) begin
              src_lp = saved_lp;
              tgt_load = 1'b1;
              req_d = 1'b1;
              seq_d = lpsc_seq_exit;
            end else begin
              rej_d = 1'b1;
            end
          end
          lpsc_cmd_shutdown: begin
            // Orderly shutdown is only taken from full power.
            if (link_q == full_power_state) begin
              link_d = idle_state;
            end else begin
              rej_d = 1'b1;
            end
          end
          lpsc_cmd_init_done: begin
            if (link_q == idle_state) begin
              init_load = 1'b1;
              link_d = full_power_state;
            end else begin
              rej_d = 1'b1;
            end
          end
          default: begin
            rej_d = 1'b1;
          end
        endcase
      end
    end else begin
      // Mid-change, every command other than power loss is refused.
      rej_d = i_cmd.valid;
      if (req_q && i_sync_cnf) begin
        req_d = 1'b0;
        cnf_d = 1'b1;
      end
      // The flag seen registered guarantees the switch is a later symbol.
      if (cnf_q && i_symbol_start) begin
        tx_load = 1'b1;
        cnf_d = 1'b0;
        tx_done_d = 1'b1;
      end
      if (ind_q && i_symbol_start) begin
        rx_load = 1'b1;
        ind_d = 1'b0;
        rx_done_d = 1'b1;
      end
      // A fresh indicate beats the clear, so no flag is lost.
      if (i_sync_ind) begin
        ind_d = 1'b1;
      end
      if (tx_done_q && rx_done_q) begin
        link_d = (seq_q == lpsc_seq_enter) ? low_power_state
                                           : full_power_state;
        seq_d = lpsc_seq_steady;
        tx_done_d = 1'b0;
        rx_done_d = 1'b0;
        ind_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      link_q <= idle_state;
      seq_q <= lpsc_seq_steady;
      req_q <= 1'b0;
      cnf_q <= 1'b0;
      ind_q <= 1'b0;
      tx_done_q <= 1'b0;
      rx_done_q <= 1'b0;
      rej_q <= 1'b0;
      used_q <= '0;
    end else begin
      link_q <= link_d;
      seq_q <= seq_d;
      req_q <= req_d;
      cnf_q <= cnf_d;
      ind_q <= ind_d;
      tx_done_q <= tx_done_d;
      rx_done_q <= rx_done_d;
      rej_q <= rej_d;
      used_q <= used_d;
    end
  end

  lpsc_path_bank #(
    .NPATH(NPATH),
    .LPW(LPW)
  ) u_bank (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_init_load(init_load),
    .i_tgt_load(tgt_load),
    .i_save(save),
    .i_tx_load(tx_load),
    .i_rx_load(rx_load),
    .i_src_lp(src_lp),
    .o_tx_lp(o_tx_lp),
    .o_rx_lp(o_rx_lp),
    .o_saved_lp(saved_lp)
  );

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  // There is no trim input: trim cannot reach the sublayer's state.
  assign o_stat.link = link_q;
  assign o_stat.busy = (seq_q != lpsc_seq_steady);
  assign o_stat.tc_active = (link_q != idle_state);
  assign o_stat.min_ovh_enforce = (link_q == full_power_state) &&
                                  (seq_q == lpsc_seq_steady);
  assign o_stat.reconfig_en = (link_q == full_power_state) &&
                              (seq_q == lpsc_seq_steady);
  assign o_sync_req = req_q;
  assign o_cmd_reject = rej_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_low_lp_range: assert property (
    (link_q == low_power_state && $past(link_q) != low_power_state)
    |-> (lp_ok(o_tx_lp, used_q) && o_tx_lp == o_rx_lp))
    else $error("low-power settings not applied on entry");
  chk_tx_after_cnf: assert property (
    (o_tx_lp != $past(o_tx_lp) && !$past(init_load) && $past(i_rst_n))
    |-> $past(cnf_q && i_symbol_start))
    else $error("tx settings changed without confirmed flag and symbol");
  chk_save_full: assert property (
    (save) |=> (saved_lp == $past(o_tx_lp)))
    else $error("full-power settings not saved on entry");
  chk_tc_running: assert property (
    (link_q == low_power_state) |-> o_stat.tc_active)
    else $error("sublayer stopped in low power");
  chk_ovh_relaxed: assert property (
    (link_q == low_power_state) |-> !o_stat.min_ovh_enforce)
    else $error("overhead limits enforced in low power");
  chk_reconfig_off: assert property (
    (link_q == low_power_state || o_stat.busy) |-> !o_stat.reconfig_en)
    else $error("reconfiguration enabled in low power");
  chk_exit_restore: assert property (
    ($past(seq_q) == lpsc_seq_exit && link_q == full_power_state &&
     $past(link_q) == low_power_state) |-> (o_tx_lp == saved_lp))
    else $error("full-power settings not restored on exit");
  chk_low_no_shutdown: assert property (
    (link_q == low_power_state && seq_q == lpsc_seq_steady &&
     i_cmd.valid && i_cmd.code == lpsc_cmd_shutdown)
    |=> (link_q == low_power_state) ##0 o_cmd_reject)
    else $error("shutdown accepted from low power");
  chk_idle_exit_init: assert property (
    ($past(link_q) == idle_state && link_q != idle_state)
    |-> ($past(i_cmd.valid) && $past(i_cmd.code) == lpsc_cmd_init_done
         && link_q == full_power_state))
    else $error("idle left without initialization");
  chk_rx_after_ind: assert property (
    (o_rx_lp != $past(o_rx_lp) && !$past(init_load) && $past(i_rst_n))
    |-> $past(ind_q && i_symbol_start))
    else $error("rx settings changed without indicated flag and symbol");
  chk_req_until_cnf: assert property (
    (o_sync_req && !i_sync_cnf && !(i_cmd.valid &&
     i_cmd.code == lpsc_cmd_power_loss)) |=> o_sync_req)
    else $error("sync request dropped before confirm");
  chk_busy_reject: assert property (
    (o_stat.busy && i_cmd.valid && i_cmd.code != lpsc_cmd_power_loss)
    |=> o_cmd_reject ##0 (link_q == $past(link_q)))
    else $error("command taken during a change");

  cov_enter_low: cover property (
    seq_q == lpsc_seq_enter ##1 link_q == low_power_state);
  cov_exit_low: cover property (
    seq_q == lpsc_seq_exit ##1 link_q == full_power_state);
  cov_loss_in_low: cover property (
    link_q == low_power_state ##1 link_q == idle_state);
  cov_init: cover property (
    link_q == idle_state ##1 link_q == full_power_state);

endmodule : lpsc_ctrl

/* File: lpsc_map.svh */
/*
  Constants of the link power state controller: bits-per-path limits for
  the low-power state and the reset value of a path setting.
  Assumes it is included by bare name from the controller and the path bank.
*/
`ifndef LPSC_MAP_SVH
`define LPSC_MAP_SVH

// ----------------------------------------------------------------------
// Low-power bits-per-path limits
// ----------------------------------------------------------------------
`define LPSC_LP_MIN 16'h0001
`define LPSC_LP_MAX 16'h0400
`define LPSC_SUM_MIN 16'h0008
`define LPSC_SUM_MAX 16'h0400

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LPSC_LP_RST 16'h0000

`endif

/* File: lpsc_pkg.sv */
/*
  Types of the link power state controller: commands from the control
  entity, link states, sequencer states and the status bundle.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lpsc_pkg;

  // ----------------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    lpsc_cmd_none = 3'b000,
    lpsc_cmd_enter_low = 3'b001,
    lpsc_cmd_exit_low = 3'b010,
    lpsc_cmd_shutdown = 3'b011,
    lpsc_cmd_power_loss = 3'b100,
    lpsc_cmd_init_done = 3'b101
  } lpsc_cmd_e;

  typedef enum logic [1:0] {
    full_power_state = 2'b00,
    low_power_state = 2'b01,
    idle_state = 2'b10
  } lpsc_link_e;

  typedef enum logic [1:0] {
    lpsc_seq_steady = 2'b00,
    lpsc_seq_enter = 2'b01,
    lpsc_seq_exit = 2'b10
  } lpsc_seq_e;

  // ----------------------------------------------------------------------
  // Bundles
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    lpsc_cmd_e code;
  } lpsc_cmd_s;

  typedef struct packed {
    lpsc_link_e link;
    logic busy;
    logic reconfig_en;
    logic min_ovh_enforce;
    logic tc_active;
  } lpsc_stat_s;

endpackage : lpsc_pkg

/* File: lpsc_path_bank.sv */
/*
  Per-path bits-per-symbol storage: the pending target, the transmit and
  receive settings in force, and the saved full-power settings.
  Assumes the controller raises each load strobe for one cycle only.
*/
`include "lpsc_map.svh"

module lpsc_path_bank #(
  parameter int NPATH = 4,
  parameter int LPW = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Load strobes
  input wire logic i_init_load,
  input wire logic i_tgt_load,
  input wire logic i_save,
  input wire logic i_tx_load,
  input wire logic i_rx_load,
  // Values
  input wire logic [NPATH*LPW-1:0] i_src_lp,
  output logic [NPATH*LPW-1:0] o_tx_lp,
  output logic [NPATH*LPW-1:0] o_rx_lp,
  output logic [NPATH*LPW-1:0] o_saved_lp
);
  import lpsc_pkg::*;

  for (genvar p = 0; p < NPATH; p++) begin : g_path
    logic [LPW-1:0] tgt_q, tgt_d, tx_q, tx_d, rx_q, rx_d, sav_q, sav_d;
    logic [LPW-1:0] src;

    assign src = i_src_lp[p*LPW +: LPW];

    always_comb begin
      tgt_d = (i_tgt_load || i_init_load) ? src : tgt_q;
      tx_d = i_init_load ? src : (i_tx_load ? tgt_q : tx_q);
      rx_d = i_init_load ? src : (i_rx_load ? tgt_q : rx_q);
      // The setting in force at full power is kept for the return trip.
      sav_d = i_save ? tx_q : sav_q;
    end

    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        tgt_q <= LPW'(`LPSC_LP_RST);
        tx_q <= LPW'(`LPSC_LP_RST);
        rx_q <= LPW'(`LPSC_LP_RST);
        sav_q <= LPW'(`LPSC_LP_RST);
      end else begin
        tgt_q <= tgt_d;
        tx_q <= tx_d;
        rx_q <= rx_d;
        sav_q <= sav_d;
      end
    end

    assign o_tx_lp[p*LPW +: LPW] = tx_q;
    assign o_rx_lp[p*LPW +: LPW] = rx_q;
    assign o_saved_lp[p*LPW +: LPW] = sav_q;
  end

endmodule : lpsc_path_bank

/* File: lpsc_media_model.sv */
/*
  Behavioural physical media function facing the link power state
  controller: symbol boundaries, sync flag confirm and far-end indicate.
  Assumes the controller's sync request is a level held until confirm.
*/
module lpsc_media_model #(
  parameter int SYMP = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Controller side
  input wire logic i_sync_req,
  input wire logic i_slow,
  output logic o_symbol_start,
  output logic o_sync_cnf,
  output logic o_sync_ind
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_q;
  logic [3:0] sym_q;
  logic req_q;
  logic [5:0] dly_cnf;
  logic [5:0] dly_ind;

  // Slow mode lets the far-end flag arrive long before our own confirm.
  assign dly_cnf = i_slow ? 6'h13 : 6'h02;
  assign dly_ind = i_slow ? 6'h0b : 6'h05;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q <= 6'h00;
      sym_q <= 4'h0;
      req_q <= 1'b0;
      o_symbol_start <= 1'b0;
      o_sync_cnf <= 1'b0;
      o_sync_ind <= 1'b0;
    end else begin
      req_q <= i_sync_req;
      sym_q <= (sym_q == 4'(SYMP - 1)) ? 4'h0 : sym_q + 4'h1;
      o_symbol_start <= (sym_q == 4'h0);
      if (i_sync_req && !req_q) begin
        cnt_q <= 6'h01;
      end else if (cnt_q != 6'h00 && cnt_q != 6'h3f) begin
        cnt_q <= cnt_q + 6'h01;
      end
      o_sync_cnf <= i_sync_req && (cnt_q == dly_cnf);
      o_sync_ind <= (cnt_q == dly_ind);
    end
  end
endmodule : lpsc_media_model

/* File: testbench.sv */
/*
  Self-checking bench of the link power state controller with a media
  function model on the far side.
  Assumes the package, the map header and both design modules compiled.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import lpsc_pkg::*;
  localparam logic [63:0] FULL = 64'h0120_00f0_0200_0080;
  localparam logic [63:0] LOW_A = 64'h0005_0001_0001_0001;
  localparam logic [63:0] LOW_B = 64'h03fd_0001_0001_0001;
  // Path 0 is zero but unused, so the set must still be taken.
  localparam logic [63:0] LOW_C = 64'h0004_0004_0004_0000;
  logic i_mclk = 1'b0;
  logic i_rst_n;
  lpsc_cmd_s i_cmd;
  logic [3:0] i_path_used;
  logic [63:0] i_low_lp;
  logic [63:0] i_full_lp;
  logic o_cmd_reject;
  lpsc_stat_s o_stat;
  logic i_symbol_start;
  logic i_sync_cnf;
  logic i_sync_ind;
  logic o_sync_req;
  logic [63:0] o_tx_lp;
  logic [63:0] o_rx_lp;
  logic media_slow;
  int fails;
  int n_compared;

  lpsc_ctrl #(.NPATH(4), .LPW(16)) lpsc_ctrl_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(i_cmd),
    .i_path_used(i_path_used), .i_low_lp(i_low_lp),
    .i_full_lp(i_full_lp), .o_cmd_reject(o_cmd_reject), .o_stat(o_stat),
    .i_symbol_start(i_symbol_start), .i_sync_cnf(i_sync_cnf),
    .i_sync_ind(i_sync_ind), .o_sync_req(o_sync_req),
    .o_tx_lp(o_tx_lp), .o_rx_lp(o_rx_lp));

  lpsc_media_model #(.SYMP(8)) lpsc_media_model_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sync_req(o_sync_req),
    .i_slow(media_slow), .o_symbol_start(i_symbol_start),
    .o_sync_cnf(i_sync_cnf), .o_sync_ind(i_sync_ind));

  always #50 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic expire(input string what);
    fails++;
    $display("MISMATCH %0t wait expired: %s", $time, what);
    tally_and_finish();
  endtask : expire

  // One-cycle command pulse; the reject flag is read in its only cycle.
  task automatic send(input lpsc_cmd_e c, input logic rej);
    @(posedge i_mclk);
    i_cmd <= '{1'b1, c};
    @(posedge i_mclk);
    i_cmd <= '{1'b0, lpsc_cmd_none};
    #1;
    cmp(64'(o_cmd_reject), 64'(rej));
  endtask : send

  task automatic wait_link(input lpsc_link_e l);
    int n;
    for (n = 0; n < 100 && o_stat.link !== l; n++) @(posedge i_mclk);
    #1;
    if (o_stat.link !== l) expire("link state");
  endtask : wait_link

  // Values must hold through the symbol start that shares the flag's
  // cycle and change only after the following one.
  task automatic watch(input logic rx, input logic [63:0] oldv,
                       input logic [63:0] newv);
    logic armed;
    int n;
    armed = 1'b0;
    for (n = 0; n < 100; n++) begin
      @(posedge i_mclk);
      if (armed && i_symbol_start) begin
        cmp(rx ? o_rx_lp : o_tx_lp, oldv);
        #1;
        cmp(rx ? o_rx_lp : o_tx_lp, newv);
        return;
      end
      if (rx ? i_sync_ind : i_sync_cnf) armed = 1'b1;
    end
    expire("switch");
  endtask : watch

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_idle;
    cmp(64'(o_stat), 64'({idle_state, 4'b0000}));
    cmp(o_tx_lp, 64'h0000_0000_0000_0000);
    send(lpsc_cmd_enter_low, 1'b1);
    send(lpsc_cmd_exit_low, 1'b1);
    send(lpsc_cmd_shutdown, 1'b1);
    send(lpsc_cmd_power_loss, 1'b1);
  endtask : t_idle

  task automatic t_init;
    send(lpsc_cmd_init_done, 1'b0);
    cmp(64'(o_stat), 64'({full_power_state, 4'b0111}));
    cmp(o_tx_lp, FULL);
    cmp(o_rx_lp, FULL);
  endtask : t_init

  task automatic t_bad;
    logic [63:0] bad [3];
    bad = '{64'h0004_0001_0001_0001, 64'h0004_0004_0004_0000,
            64'h03fd_0002_0001_0001};
    foreach (bad[k]) begin
      @(posedge i_mclk);
      i_low_lp <= bad[k];
      send(lpsc_cmd_enter_low, 1'b1);
    end
    cmp(64'(o_stat), 64'({full_power_state, 4'b0111}));
  endtask : t_bad

  task automatic t_enter(input logic [63:0] lp, input logic s,
                         input logic [3:0] u);
    @(posedge i_mclk);
    i_low_lp <= lp;
    i_path_used <= u;
    media_slow <= s;
    send(lpsc_cmd_enter_low, 1'b0);
    cmp(64'(o_stat), 64'({full_power_state, 4'b1001}));
    cmp(64'(o_sync_req), 64'h0000_0000_0000_0001);
    fork
      watch(1'b0, FULL, lp);
      watch(1'b1, FULL, lp);
      send(lpsc_cmd_exit_low, 1'b1);
    join
    wait_link(low_power_state);
    cmp(64'(o_stat), 64'({low_power_state, 4'b0001}));
    cmp(o_tx_lp, lp);
  endtask : t_enter

  task automatic t_low_refusals;
    send(lpsc_cmd_shutdown, 1'b1);
    send(lpsc_cmd_enter_low, 1'b1);
    send(lpsc_cmd_init_done, 1'b1);
  endtask : t_low_refusals

  task automatic t_exit(input logic [63:0] lp);
    send(lpsc_cmd_exit_low, 1'b0);
    fork
      watch(1'b0, lp, FULL);
      watch(1'b1, lp, FULL);
    join
    wait_link(full_power_state);
    cmp(64'(o_stat), 64'({full_power_state, 4'b0111}));
  endtask : t_exit

  task automatic t_abort;
    @(posedge i_mclk);
    i_low_lp <= LOW_A;
    media_slow <= 1'b1;
    send(lpsc_cmd_enter_low, 1'b0);
    repeat (3) @(posedge i_mclk);
    send(lpsc_cmd_power_loss, 1'b0);
    cmp(64'(o_stat), 64'({idle_state, 4'b0000}));
    cmp(64'(o_sync_req), 64'h0000_0000_0000_0000);
  endtask : t_abort

  initial begin
    fails = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    i_cmd = '{1'b0, lpsc_cmd_none};
    i_path_used = 4'hf;
    i_low_lp = LOW_A;
    i_full_lp = FULL;
    media_slow = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    t_idle();
    t_init();
    t_bad();
    t_enter(LOW_A, 1'b0, 4'hf);
    t_low_refusals();
    t_exit(LOW_A);
    t_enter(LOW_B, 1'b1, 4'hf);
    send(lpsc_cmd_power_loss, 1'b0);
    cmp(64'(o_stat), 64'({idle_state, 4'b0000}));
    t_init();
    t_abort();
    t_init();
    t_enter(LOW_C, 1'b0, 4'he);
    t_exit(LOW_C);
    send(lpsc_cmd_shutdown, 1'b0);
    cmp(64'(o_stat), 64'({idle_state, 4'b0000}));
    tally_and_finish();
  end
endmodule : testbench
